// >>> hw/dbc_pkg.sv
// Package of constants and types for the debug breakpoint control block.
package dbc_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [4:0] OFS_CTRL   = 5'h00;
  localparam logic [4:0] OFS_CMP0   = 5'h04;
  localparam logic [4:0] OFS_CMP1   = 5'h08;
  localparam logic [4:0] OFS_CMP2   = 5'h0c;
  localparam logic [4:0] OFS_CMP3   = 5'h10;
  localparam logic [4:0] OFS_STATUS = 5'h14;

  // Field positions inside breakpoint_control.
  localparam int BIT_BRK_NEXT  = 7;
  localparam int BIT_CMP3_EN   = 6;
  localparam int BIT_CMP0_EN   = 3;
  localparam int BIT_IGN_LOW_1 = 2;

  // Field positions inside the status register.
  localparam int BIT_ST_HALTED = 0;
  localparam int BIT_ST_STRAP  = 1;
  localparam int BIT_ST_HIT    = 2;
  localparam int POS_ST_WHICH  = 4;

  // Reset values.
  localparam logic [7:0]  CTRL_RESET = 8'h00;
  localparam logic [23:0] CMP_RESET  = 24'h000000;
  localparam logic [31:0] RD_IDLE    = 32'h00000000;

  // Geometry.
  localparam int ADDR_W  = 24;
  localparam int NUM_CMP = 4;
  localparam int MASKED_CMP = 1;

  // Fetch presented by the core for one byte.
  typedef struct packed {
    logic              valid;
    logic              first;
    logic [ADDR_W-1:0] addr;
  } dbc_fetch_s;

  // Avalon-MM request from the master.
  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } dbc_avreq_s;

  // Core-side halt sequencer.
  typedef enum logic {
    ST_RUN  = 1'b0,
    ST_HALT = 1'b1
  } dbc_state_e;

endpackage

// >>> hw/dbc_sync2.sv
// Two flip-flop synchroniser for a single level from outside the domain.
`timescale 1ns/1ps
module dbc_sync2 (
  input  wire logic ref_clk,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;
  logic sync_q;

  // No reset here, so the chain follows the pins during reset and the
  // level at the release is already settled when it is sampled.
  always_ff @(posedge ref_clk) begin
    meta_q <= async_in;
    sync_q <= meta_q;
  end

  assign sync_out = sync_q;

endmodule

// >>> hw/dbc_addr_cmp.sv
// One fetch address comparator with an optional low byte mask.
`timescale 1ns/1ps
module dbc_addr_cmp
  import dbc_pkg::*;
(
  input  wire logic              enable,
  input  wire logic              ign_low,
  input  wire logic [ADDR_W-1:0] match_addr,
  input  wire logic [ADDR_W-1:0] fetch_addr,
  output logic                   hit
);

  logic upper_eq;
  logic low_eq;

  // Upper and high bytes always take part; the low byte only when unmasked.
  assign upper_eq = (fetch_addr[23:8] == match_addr[23:8]);
  assign low_eq   = (fetch_addr[7:0] == match_addr[7:0]) | ign_low;
  assign hit      = enable & upper_eq & low_eq;

endmodule

// >>> hw/dbc_brk_ctrl.sv
// Breakpoint control for the serial debug port, with Avalon-MM registers.
//
// Overview of operation
// - Break bit set: halt the core before its next instruction.
// - Clearing break_next_instr releases a halt in progress.
// - A breakpoint halt happens only at an instruction's first opcode byte.
// - Clock pin high and data pin low at reset end sets the break bit.
// - A comparator match that halts sets break_next_instr automatically.
// - Writing a 1 to break_next_instr forces an immediate halt.
// - Bits 6 to 3 enable comparators 3 to 0; only enabled ones halt.
// - Mask bit clear: comparator 1 compares all 24 address bits.
// - Mask bit set: comparator 1 compares bits 23 to 8, a 256-byte page.
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module dbc_brk_ctrl
  import dbc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire dbc_avreq_s  av_req,
  output logic [31:0]      av_readdata,
  output logic             av_waitrequest,
  input  wire dbc_fetch_s  fetch,
  output logic             fetch_go,
  output logic             cpu_halt,
  input  wire logic        debug_clock_pin,
  input  wire logic        debug_data_pin
);

  // The core holds each fetch byte until fetch_go pulses, so a halt is a
  // fetch that is not granted; cpu_halt only reports that state outward.
  // Address matches are judged on the byte presented, never on a later
  // one, so the core always stops on an instruction boundary.
  // Register state.
  logic [7:0]        ctrl_q;
  logic [7:0]        ctrl_d;
  logic [ADDR_W-1:0] cmp_q [NUM_CMP];
  logic [ADDR_W-1:0] cmp_d [NUM_CMP];
  logic              strap_q;
  logic              strap_d;
  logic              hit_seen_q;
  logic              hit_seen_d;
  logic [1:0]        which_q;
  logic [1:0]        which_d;
  logic              rst_seen_q;

  // Bus slave state.
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        wait_q;
  logic        wait_d;

  // Halt sequencer state.
  dbc_state_e state_q;
  dbc_state_e state_d;
  logic       go_q;
  logic       go_d;
  logic       halt_q;
  logic       halt_d;

  // Combinational helpers.
  logic               clk_pin_s;
  logic               data_pin_s;
  logic [NUM_CMP-1:0] cmp_hit;
  logic               any_hit;
  logic [1:0]         hit_idx;
  logic               first_fetch;
  logic               later_fetch;
  logic               bus_wr;
  logic               bus_rd_start;
  logic               brk_set;
  logic [31:0]        wmask;

  // The pins are only strap inputs here; the serial link itself is
  // decoded elsewhere and never reaches this block.
  // Pin levels come from another domain, so both pass two flip-flops.
  dbc_sync2 u_sync_clk (
    .ref_clk  (ref_clk),
    .async_in (debug_clock_pin),
    .sync_out (clk_pin_s)
  );

  dbc_sync2 u_sync_data (
    .ref_clk  (ref_clk),
    .async_in (debug_data_pin),
    .sync_out (data_pin_s)
  );

  // One comparator per break address. Comparators 0, 2 and 3 always
  // compare all 24 bits; only comparator 1 has the low byte mask.
  for (genvar i = 0; i < NUM_CMP; i++) begin : g_cmp
    dbc_addr_cmp u_cmp (
      .enable     (ctrl_q[BIT_CMP0_EN + i]),
      .ign_low    ((i == MASKED_CMP) ? ctrl_q[BIT_IGN_LOW_1]
                                     : 1'b0),
      .match_addr (cmp_q[i]),
      .fetch_addr (fetch.addr),
      .hit        (cmp_hit[i])
    );
  end

  // Lowest numbered hitting comparator is reported in the status.
  // Only the index is kept; a double hit still halts just once.
  always_comb begin
    hit_idx = 2'h0;
    for (int k = NUM_CMP - 1; k >= 0; k--) begin
      if (cmp_hit[k]) begin
        hit_idx = k[1:0];
      end
    end
  end

  // Fetch classes seen by the sequencer; a granted fetch is not re-judged.
  // go_q masks the fetch for one cycle because the core drops it only at
  // the edge that sees the go pulse.
  assign first_fetch = fetch.valid & fetch.first & ~go_q;
  assign later_fetch = fetch.valid & ~fetch.first & ~go_q;
  // Comparators only count on the first opcode byte of an instruction.
  assign any_hit     = first_fetch & (|cmp_hit);

  // A request is answered one cycle after it appears; a write takes effect at
  // the edge where the master sees waitrequest low, while a read samples the registers one edge earlier.
  assign bus_wr       = av_req.write & ~wait_q;
  assign bus_rd_start = av_req.read & wait_q;
  // Byte lanes of a comparator write land on their own, so the host can
  // change one match byte without a read-modify-write.
  assign wmask        = {{8{av_req.byteenable[3]}},
                         {8{av_req.byteenable[2]}},
                         {8{av_req.byteenable[1]}},
                         {8{av_req.byteenable[0]}}};

  // Bus handshake and read data capture.
  always_comb begin
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    if ((av_req.read | av_req.write) & wait_q) begin
      wait_d = 1'b0;
    end
    if (bus_rd_start) begin
      rdata_d = RD_IDLE;
      unique case (av_req.address)
        OFS_CTRL:   rdata_d = {24'h000000, ctrl_q};
        OFS_CMP0:   rdata_d = {8'h00, cmp_q[0]};
        OFS_CMP1:   rdata_d = {8'h00, cmp_q[1]};
        OFS_CMP2:   rdata_d = {8'h00, cmp_q[2]};
        OFS_CMP3:   rdata_d = {8'h00, cmp_q[3]};
        OFS_STATUS: begin
          // Halted, strap seen, sticky hit and the index that hit.
          rdata_d[BIT_ST_HALTED]              = halt_q;
          rdata_d[BIT_ST_STRAP]               = strap_q;
          rdata_d[BIT_ST_HIT]                 = hit_seen_q;
          rdata_d[POS_ST_WHICH+1:POS_ST_WHICH] = which_q;
        end
        default:    rdata_d = RD_IDLE;
      endcase
    end
  end

  // Bus registers; waitrequest idles high, so no request is ever taken
  // while the block is in reset.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wait_q  <= 1'b1;
      rdata_q <= RD_IDLE;
    end else begin
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // The break bit is set by hardware in several ways; any set wins over a
  // software clear written in the same cycle so no break is ever lost.
  // A hit during a halt does not set the bit again: the held fetch is the
  // one that caused the halt, and setting it would undo the release.
  assign brk_set = any_hit & (state_q == ST_RUN);

  // Control, comparator and status register updates.
  // Order matters: bus writes come first, then hardware sets override.
  always_comb begin
    ctrl_d     = ctrl_q;
    strap_d    = strap_q;
    hit_seen_d = hit_seen_q;
    which_d    = which_q;
    for (int k = 0; k < NUM_CMP; k++) begin
      cmp_d[k] = cmp_q[k];
    end
    if (bus_wr) begin
      unique case (av_req.address)
        OFS_CTRL: begin
          if (av_req.byteenable[0]) begin
            ctrl_d = av_req.writedata[7:0];
          end
        end
        OFS_CMP0, OFS_CMP1, OFS_CMP2, OFS_CMP3: begin
          for (int k = 0; k < NUM_CMP; k++) begin
            if (av_req.address == OFS_CMP0 + 5'(4 * k)) begin
              cmp_d[k] = (cmp_q[k] & ~wmask[23:0]) |
                         (av_req.writedata[23:0] & wmask[23:0]);
            end
          end
        end
        OFS_STATUS: begin
          // Writing a 1 clears the sticky hit flag unless a new hit lands.
          if (av_req.byteenable[0] & av_req.writedata[BIT_ST_HIT]) begin
            hit_seen_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (brk_set) begin
      ctrl_d[BIT_BRK_NEXT] = 1'b1;
      hit_seen_d           = 1'b1;
      which_d              = hit_idx;
    end
    // Strap is read in the first cycle after reset is released.
    if (rst_seen_q) begin
      strap_d = clk_pin_s & ~data_pin_s;
      if (clk_pin_s & ~data_pin_s) begin
        ctrl_d[BIT_BRK_NEXT] = 1'b1;
      end
    end
  end

  // Register file flip-flops; the strap marker is set through reset so
  // the first cycle after release samples the pins exactly once.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_q     <= CTRL_RESET;
      strap_q    <= 1'b0;
      hit_seen_q <= 1'b0;
      which_q    <= 2'h0;
      rst_seen_q <= 1'b1;
      for (int k = 0; k < NUM_CMP; k++) begin
        cmp_q[k] <= CMP_RESET;
      end
    end else begin
      ctrl_q     <= ctrl_d;
      strap_q    <= strap_d;
      hit_seen_q <= hit_seen_d;
      which_q    <= which_d;
      rst_seen_q <= 1'b0;
      for (int k = 0; k < NUM_CMP; k++) begin
        cmp_q[k] <= cmp_d[k];
      end
    end
  end

  // Halt sequencer. The core holds a fetch until fetch_go pulses. Later
  // bytes of an instruction always pass, so the core never stops inside
  // one; a halt only stands between instructions or at a first byte.
  // Limitation: a later byte pending at a forced halt is granted first,
  // so the halt then stands one cycle later.
  always_comb begin
    state_d = state_q;
    go_d    = 1'b0;
    unique case (state_q)
      ST_RUN: begin
        if (later_fetch) begin
          go_d = 1'b1;
        end else if (ctrl_q[BIT_BRK_NEXT] | any_hit) begin
          state_d = ST_HALT;
        end else if (first_fetch) begin
          go_d = 1'b1;
        end
      end
      ST_HALT: begin
        if (later_fetch) begin
          go_d = 1'b1;
        end else if (~ctrl_q[BIT_BRK_NEXT] & ~brk_set) begin
          // Release grants the held fetch at once; re-judging it would
          // trap the core on the same breakpoint forever.
          state_d = ST_RUN;
          go_d    = first_fetch;
        end
      end
    endcase
    halt_d = (state_d == ST_HALT);
  end

  // Sequencer flip-flops; halt_q mirrors the state so that cpu_halt is
  // registered and free of glitches.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_RUN;
      go_q    <= 1'b0;
      halt_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      go_q    <= go_d;
      halt_q  <= halt_d;
    end
  end

  // Outputs straight from flip-flops, so the core and the bus see no
  // combinational path through this block.
  assign av_readdata    = rdata_q;
  assign av_waitrequest = wait_q;
  assign fetch_go       = go_q;
  assign cpu_halt       = halt_q;

endmodule

// >>> tb/dbc_brk_props.sv
// Assertion checker on the breakpoint control block's ports.
`timescale 1ns/1ps
module dbc_brk_props
  import dbc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire dbc_avreq_s  av_req,
  input wire logic [31:0] av_readdata,
  input wire logic        av_waitrequest,
  input wire dbc_fetch_s  fetch,
  input wire logic        fetch_go,
  input wire logic        cpu_halt,
  input wire logic        debug_clock_pin,
  input wire logic        debug_data_pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Control write accepted at this edge; v is the break bit written.
  sequence s_ctl(v);
    av_req.write && !av_waitrequest && av_req.address == OFS_CTRL &&
    av_req.byteenable[0] && av_req.writedata[BIT_BRK_NEXT] == v;
  endsequence
  a_wait_pulse: assert property (!av_waitrequest |=> av_waitrequest)
    else $error("waitrequest low too long");
  a_req_answer: assert property ((av_req.read || av_req.write) &&
    av_waitrequest |=> !av_waitrequest) else $error("no bus answer");
  a_later_go: assert property (
    fetch.valid && !fetch.first && !fetch_go |=> fetch_go)
    else $error("later byte held");
  a_fetch_answer: assert property (
    fetch.valid && fetch.first && !fetch_go && !cpu_halt
    |=> fetch_go ^ cpu_halt) else $error("first byte not judged");
  a_release_go: assert property (
    $fell(cpu_halt) && fetch.valid |-> fetch_go) else $error("no go");
  a_force_halt: assert property (
    s_ctl(1'b1) |-> ##[1:2] cpu_halt) else $error("no forced halt");
  a_clear_release: assert property (
    cpu_halt ##0 s_ctl(1'b0) |-> ##[1:2] !cpu_halt)
    else $error("halt kept");
  a_strap_halt: assert property (
    $fell(reset) && debug_clock_pin && !debug_data_pin
    |-> ##[1:3] cpu_halt) else $error("no strap halt");
endmodule

bind dbc_brk_ctrl dbc_brk_props u_props (.ref_clk(ref_clk), .reset(reset),
  .av_req(av_req), .av_readdata(av_readdata),
  .av_waitrequest(av_waitrequest), .fetch(fetch), .fetch_go(fetch_go),
  .cpu_halt(cpu_halt), .debug_clock_pin(debug_clock_pin),
  .debug_data_pin(debug_data_pin));

// >>> tb/dbc_core_model.sv
// Core stand-in: holds one fetch byte until go, then scrambles it.
`timescale 1ns/1ps
module dbc_core_model
  import dbc_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        start,
  input wire logic        first,
  input wire logic [23:0] addr,
  input wire logic        fetch_go,
  output dbc_fetch_s      fetch
);
  // After go the address is inverted so a stale byte never looks held.
  initial fetch = '0;
  always @(posedge ref_clk) begin
    if (start) fetch <= '{1'b1, first, addr};
    else if (fetch_go) fetch <= '{1'b0, 1'b0, ~fetch.addr};
  end
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the breakpoint control block.
`timescale 1ns/1ps
module testbench
  import dbc_pkg::*;
;
  logic        ref_clk, reset, st, ff, pc, pd, wq, go, halt;
  logic [23:0] fa;
  logic [31:0] rd, q;
  dbc_avreq_s  req;
  dbc_fetch_s  fetch;
  int          error_cnt, checked, gos, cyc;

  dbc_brk_ctrl uut (.ref_clk(ref_clk), .reset(reset), .av_req(req),
    .av_readdata(rd), .av_waitrequest(wq), .fetch(fetch), .fetch_go(go),
    .cpu_halt(halt), .debug_clock_pin(pc), .debug_data_pin(pd));
  dbc_core_model core (.ref_clk(ref_clk), .start(st), .first(ff),
    .addr(fa), .fetch_go(go), .fetch(fetch));

  // The 100 ns clock.
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Go pulses are counted here; the cycle limit stops a hung run.
  always @(posedge ref_clk) begin
    cyc++;
    if (go !== 1'b0) gos++;
    if (cyc == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // One Avalon-MM transfer; the request stands until waitrequest is low.
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    req <= '{~w, w, a, 4'hf, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (wq !== 1'b0);
    q = rd;
    req <= '0;
    @(posedge ref_clk);
    chk("bus wait", 32'(n), 32'h2);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", q, e);
  endtask

  // Present one byte, then count go pulses and look at the halt level.
  task automatic run(input logic [23:0] a, input logic f, input int eg,
                     input logic eh);
    int g;
    g = gos;
    st <= 1'b1;
    fa <= a;
    ff <= f;
    @(posedge ref_clk);
    st <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("go count", gos - g, eg);
    chk("halt", {31'h0, halt}, {31'h0, eh});
  endtask

  task automatic rel(input logic [7:0] c);
    int g;
    g = gos;
    bus(1'b1, OFS_CTRL, {24'h0, c});
    repeat (3) @(posedge ref_clk);
    chk("release go", gos - g, 1);
    chk("release", {31'h0, halt}, 32'h0);
  endtask

  // Pins stay put through the whole reset so the strap is sampled clean.
  task automatic rst(input logic c, input logic d);
    reset <= 1'b1;
    pc <= c;
    pd <= d;
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Main sequence of tests.
  initial begin
    reset = 1'b1;
    req = '0;
    {st, ff, fa, pc, pd} = 28'h1;
    rst(1'b0, 1'b1);
    rdc(OFS_CTRL, {24'h0, CTRL_RESET});
    rdc(OFS_CMP1, {8'h0, CMP_RESET});
    bus(1'b1, 5'h18, 32'hff);
    rdc(5'h18, 32'h0);
    $display("test reset done");
    rst(1'b1, 1'b0);
    repeat (3) @(posedge ref_clk);
    rdc(OFS_CTRL, 32'h80);
    run(24'h000100, 1'b1, 0, 1'b1);
    rel(8'h00);
    bus(1'b1, OFS_CTRL, 32'h80);
    run(24'h000201, 1'b0, 1, 1'b1);
    run(24'h000202, 1'b1, 0, 1'b1);
    rel(8'h00);
    $display("test break bit done");
    for (int i = 0; i < NUM_CMP; i++)
      bus(1'b1, OFS_CMP0 + 5'(4 * i), {8'h0, 24'h3c5a00 + 24'(i)});
    for (int i = 0; i < NUM_CMP; i++) begin
      bus(1'b1, OFS_CTRL, 32'(1 << (BIT_CMP0_EN + i)));
      run(24'h3c5a00 + 24'((i + 1) % 4), 1'b1, 1, 1'b0);
      run(24'h3c5a00 + 24'(i), 1'b1, 0, 1'b1);
      rdc(OFS_CTRL, 32'h80 | 32'(1 << (BIT_CMP0_EN + i)));
      rdc(OFS_STATUS, 32'h7 | 32'(i << POS_ST_WHICH));
      rel(8'(1 << (BIT_CMP0_EN + i)));
    end
    bus(1'b1, OFS_STATUS, 32'h4);
    rdc(OFS_STATUS, 32'h32);
    $display("test comparators done");
    bus(1'b1, OFS_CMP1, 32'h4567ab);
    bus(1'b1, OFS_CTRL, 32'h10);
    run(24'h456700, 1'b1, 1, 1'b0);
    run(24'h4567ab, 1'b1, 0, 1'b1);
    rel(8'h10);
    bus(1'b1, OFS_CTRL, 32'h14);
    run(24'h4567ff, 1'b1, 0, 1'b1);
    rel(8'h14);
    run(24'h456800, 1'b1, 1, 1'b0);
    $display("test low byte mask done");
    wrap_up();
  end
endmodule
